// file: include/bfsc_consts.svh
// Purpose: Constants for the fourth buck regulator control register bank
// Assumes: Register port carries 8-bit addresses and 8-bit data
// Notes: Offsets, field positions, reset values and codes
`ifndef BFSC_CONSTS_SVH
`define BFSC_CONSTS_SVH
`define BFSC_ADDR_NORMAL 8'h4a
`define BFSC_ADDR_STANDBY 8'h4b
`define BFSC_ADDR_SLEEP 8'h4c
`define BFSC_ADDR_MODE 8'h4d
`define BFSC_ADDR_CONF 8'h4e
`define BFSC_RST_SETPOINT 6'h00
`define BFSC_RST_MODE 4'h8
`define BFSC_RST_SLEEP_BEH 1'h0
`define BFSC_RST_CONF 8'h00
`define BFSC_SP_MSB 5
`define BFSC_MODE_MSB 3
`define BFSC_SLEEP_BEH_BIT 5
`define BFSC_ILIM_BIT 0
`define BFSC_CONF_SPARE_BIT 1
`define BFSC_FREQ_LSB 2
`define BFSC_PHASE_LSB 4
`define BFSC_SLEW_LSB 6
`define BFSC_SP_MIN_CODE 6'h09
`define BFSC_SP_MIN_MV 16'd625
`define BFSC_SP_STEP_MV 16'd25
`define BFSC_MODE_OFF 4'h0
`define BFSC_MODE_PWM 4'h5
`define BFSC_MODE_PFM 4'h8
`endif

// file: include/bfsc_pkg.sv
// Purpose: Types for the fourth buck regulator control register bank
// Assumes: Constants come from bfsc_consts.svh
// Notes: Holds types only
package bfsc_pkg;
  // Power state of the device as seen by this block
  typedef enum logic [1:0] {
    BFSC_PS_NORMAL = 2'b00,
    BFSC_PS_STANDBY = 2'b01,
    BFSC_PS_SLEEP = 2'b10
  } bfsc_pstate_t;

  // Lock state machine for the tracking variant
  typedef enum logic [0:0] {
    BFSC_ST_OPEN = 1'b0,
    BFSC_ST_LOCKED = 1'b1
  } bfsc_lock_t;

  typedef struct packed {
    bfsc_lock_t lock;
    logic [5:0] sp_normal;
    logic [5:0] sp_standby;
    logic [5:0] sp_sleep;
    logic [3:0] mode;
    logic sleep_beh;
    logic [7:0] conf;
    logic [7:0] rdata;
    logic [5:0] act_code;
    logic [15:0] act_mv;
    logic [3:0] act_mode;
    logic track;
    logic locked;
  } bfsc_state_t;
endpackage

// file: tb/bfsc_host_model.sv
// Purpose: Host side of the register port
// Assumes: One-cycle strobes, one byte each
// Notes: Released lines show inverted data so stale values never match
`timescale 1ns/1ns
module bfsc_host_model (
  input wire logic clk_i,
  output logic wr_o = 1'h0,
  output logic rd_o = 1'h0,
  output logic [7:0] adr_o = 8'h00,
  output logic [7:0] dat_o = 8'h00
);
  // All setup goes through these byte accesses
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    wr_o <= 1'h0;
    rd_o <= 1'h0;
    adr_o <= ~a;
    dat_o <= ~d;
  endtask
endmodule // bfsc_host_model

// file: tb/bfsc_top_props.sv
// Purpose: Port checks for bfsc_top
// Assumes: Strap held steady outside reset
// Notes: Derived outputs lag by up to two edges
`timescale 1ns/1ns
module bfsc_top_props (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic track_variant_i,
  input wire logic [15:0] reg3_mv_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [15:0] target_mv_o,
  input wire logic [3:0] active_mode_o,
  input wire logic locked_o,
  input wire logic [7:0] conf_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_reset_vals: assert property (disable iff (1'h0) rst_i |=>
    rdata_o == 8'h00 && active_mode_o == 4'h8 && !locked_o) else $error("reset values");
  chk_track_half: assert property ((track_variant_i && $stable(reg3_mv_i))[*4]
    |-> target_mv_o == {1'h0, reg3_mv_i[15:1]}) else $error("tracking target");
  chk_track_pwm: assert property (track_variant_i[*4] |-> active_mode_o == 4'h5)
    else $error("tracking mode");
  chk_lock_hold: assert property (locked_o |=> locked_o) else $error("lock dropped");
  chk_plain_open: assert property ((!track_variant_i)[*2] |-> !locked_o)
    else $error("plain variant locked");
  chk_conf_write: assert property (wr_stb_i && addr_i == 8'h4e && !track_variant_i
    ##1 !wr_stb_i |=> conf_o == $past(wdata_i, 2)) else $error("conf write");
  chk_unmapped_rd: assert property (rd_stb_i && (addr_i < 8'h4a || addr_i > 8'h4e)
    |=> rdata_o == 8'h00) else $error("unmapped read");
  chk_sp_upper: assert property (rd_stb_i && addr_i inside {8'h4a, 8'h4b, 8'h4c}
    |=> rdata_o[7:6] == 2'h0) else $error("set point spare bits");
endmodule // bfsc_top_props
bind bfsc_top bfsc_top_props i_props (.clk_sys_i, .rst_i, .track_variant_i, .reg3_mv_i,
  .wr_stb_i, .rd_stb_i, .addr_i, .wdata_i, .rdata_o, .target_mv_o, .active_mode_o,
  .locked_o, .conf_o);

// file: tb/tb.sv
// Purpose: Self-checking bench for bfsc_top
// Assumes: Host model drives the register port
// Notes: Reads queue expected bytes; a monitor compares them
`timescale 1ns/1ns
module tb;
  logic clk_sys_i = 1'h0;
  logic rst_i = 1'h1;
  logic trk = 1'h0;
  logic sdone = 1'h0;
  logic [1:0] ps = 2'h0;
  logic [15:0] r3 = 16'h0000;
  logic wr, rd, trk_o, lck;
  logic rd_d = 1'h0;
  logic [7:0] a, d, rdat, conf, v;
  logic [5:0] code;
  logic [15:0] mv;
  logic [3:0] mode;
  logic [7:0] exp_q[$];
  int fails = 0, total_checks = 0, cyc = 0, seed = 10, i, s;
  always #25 clk_sys_i = ~clk_sys_i;
  bfsc_host_model i_host (.clk_i(clk_sys_i), .wr_o(wr), .rd_o(rd), .adr_o(a), .dat_o(d));
  bfsc_top i_dut (.clk_sys_i, .rst_i, .track_variant_i(trk), .startup_done_i(sdone),
    .power_state_i(ps), .reg3_mv_i(r3), .wr_stb_i(wr), .rd_stb_i(rd), .addr_i(a),
    .wdata_i(d), .rdata_o(rdat), .active_code_o(code), .target_mv_o(mv),
    .active_mode_o(mode), .tracking_o(trk_o), .locked_o(lck), .conf_o(conf));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("fails=%0d checks=%0d", fails, total_checks);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rdx(input logic [7:0] ad, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.xfer(1'h0, ad, 8'h00);
  endtask
  // Read data lands an edge after the strobe; also cut a hang short
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      report_and_stop();
    end
    if (rd_d) check({8'h00, rdat}, {8'h00, exp_q.pop_front()});
    rd_d <= rd;
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    for (i = 0; i < 5; i++) rdx(8'h4a + i[7:0], (i == 3) ? 8'h08 : 8'h00);
    rdx(8'h4f, 8'h00);
    // Every switching mode code, read back and applied in normal state
    for (i = 0; i < 16; i++) begin
      i_host.xfer(1'h1, 8'h4d, {4'h0, i[3:0]});
      rdx(8'h4d, {4'h0, i[3:0]});
      check({12'h000, mode}, i[15:0]);
    end
    // Set points per state; first codes sit on the clamp boundary
    for (i = 0; i < 12; i++) begin
      s = i % 3;
      v = $random(seed);
      if (i < 3) v = 8'hc8 + i[7:0];
      if (i == 3) v = 8'hff;
      i_host.xfer(1'h1, 8'h4a + s[7:0], v);
      rdx(8'h4a + s[7:0], {2'h0, v[5:0]});
      ps <= s[1:0];
      repeat (3) @(posedge clk_sys_i);
      check({10'h000, code}, {10'h000, v[5:0]});
      check({12'h000, mode}, (s == 2) ? 16'h0000 : 16'h000f);
      check(mv, (v[5:0] < 6'h09) ? 16'h0271 : 16'h0271 + 16'h0019 * (v[5:0] - 6'h09));
    end
    v = $random(seed);
    i_host.xfer(1'h1, 8'h4e, v);
    i_host.xfer(1'h1, 8'h4f, ~v);
    rdx(8'h4e, v);
    check({8'h00, conf}, {8'h00, v});
    // Sleep state with the behaviour bit set must switch in PFM
    i_host.xfer(1'h1, 8'h4d, 8'h25);
    rdx(8'h4d, 8'h25);
    check({12'h000, mode}, 16'h0008);
    // Tracking variant: writable until start-up ends, then frozen
    rst_i <= 1'h1;
    trk <= 1'h1;
    r3 <= 16'h0546;
    ps <= 2'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    i_host.xfer(1'h1, 8'h4a, 8'h10);
    sdone <= 1'h1;
    i_host.xfer(1'h1, 8'h4a, 8'h20);
    rdx(8'h4a, 8'h10);
    check(mv, 16'h02a3);
    check({12'h000, mode}, 16'h0005);
    check({14'h0000, trk_o, lck}, 16'h0003);
    repeat (2) @(posedge clk_sys_i);
    report_and_stop();
  end
endmodule // tb

// file: verilog/bfsc_setpoint_decode.sv
// Purpose: Decode a six-bit set point code into millivolts
// Assumes: Pure combinational
// Notes: Undefined low codes clamp to the lowest defined voltage
`timescale 1ns/1ns
`include "bfsc_consts.svh"
module bfsc_setpoint_decode (
  input wire logic [5:0] code_i,
  output logic [15:0] mv_o
);
  logic [5:0] eff_code;

  // Clamp then scale: 625 mV at 001001, 25 mV a step
  always_comb begin
    eff_code = (code_i < `BFSC_SP_MIN_CODE) ? `BFSC_SP_MIN_CODE : code_i;
    mv_o = 16'(`BFSC_SP_MIN_MV + 16'(eff_code - `BFSC_SP_MIN_CODE) * `BFSC_SP_STEP_MV);
  end
endmodule // bfsc_setpoint_decode

// file: verilog/bfsc_top.sv
// Purpose: Register bank and mode control for the fourth buck regulator
// Assumes: A protocol engine on the control bus presents one-cycle byte strobes
// Notes: All outputs registered; tracking variant chosen by a strap port
`timescale 1ns/1ns
`include "bfsc_consts.svh"
module bfsc_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic track_variant_i,
  input wire logic startup_done_i,
  input wire logic [1:0] power_state_i,
  input wire logic [15:0] reg3_mv_i,
  input wire logic wr_stb_i,
  input wire logic rd_stb_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [5:0] active_code_o,
  output logic [15:0] target_mv_o,
  output logic [3:0] active_mode_o,
  output logic tracking_o,
  output logic locked_o,
  output logic [7:0] conf_o
);
  bfsc_pkg::bfsc_state_t st_r;
  bfsc_pkg::bfsc_state_t st_nxt;
  logic [15:0] dec_mv;
  logic [5:0] sel_code;
  logic wr_ok;

  // Set point decode shared by all three states
  bfsc_setpoint_decode u_dec (
    .code_i(sel_code),
    .mv_o(dec_mv)
  );

  // Pick the set point matching the present power state
  always_comb begin
    case (bfsc_pkg::bfsc_pstate_t'(power_state_i))
      bfsc_pkg::BFSC_PS_STANDBY: sel_code = st_r.sp_standby;
      bfsc_pkg::BFSC_PS_SLEEP: sel_code = st_r.sp_sleep;
      default: sel_code = st_r.sp_normal;
    endcase
  end

  // Write gate: in the tracking variant the lock blocks every setting once start-up is over
  assign wr_ok = wr_stb_i && (st_r.lock == bfsc_pkg::BFSC_ST_OPEN);

  // Next-state logic for registers, lock and derived outputs
  always_comb begin
    st_nxt = st_r;
    // Lock machine: the strap is only consulted when start-up completes
    case (st_r.lock)
      bfsc_pkg::BFSC_ST_OPEN: begin
        if (startup_done_i && track_variant_i) begin
          st_nxt.lock = bfsc_pkg::BFSC_ST_LOCKED;
        end
      end
      default: begin
        st_nxt.lock = bfsc_pkg::BFSC_ST_LOCKED;
      end
    endcase
    st_nxt.track = track_variant_i;

    // Register writes land in the cycle after the strobe
    if (wr_ok) begin
      if (addr_i == `BFSC_ADDR_NORMAL) begin
        st_nxt.sp_normal = wdata_i[`BFSC_SP_MSB:0];
      end else if (addr_i == `BFSC_ADDR_STANDBY) begin
        st_nxt.sp_standby = wdata_i[`BFSC_SP_MSB:0];
      end else if (addr_i == `BFSC_ADDR_SLEEP) begin
        st_nxt.sp_sleep = wdata_i[`BFSC_SP_MSB:0];
      end else if (addr_i == `BFSC_ADDR_MODE) begin
        st_nxt.mode = wdata_i[`BFSC_MODE_MSB:0];
        st_nxt.sleep_beh = wdata_i[`BFSC_SLEEP_BEH_BIT];
      end else if (addr_i == `BFSC_ADDR_CONF) begin
        st_nxt.conf = wdata_i;
      end
    end

    // Read data: unused bits zero, unmapped addresses read zero
    st_nxt.rdata = 8'h00;
    if (rd_stb_i) begin
      if (addr_i == `BFSC_ADDR_NORMAL) begin
        st_nxt.rdata = {2'h0, st_r.sp_normal};
      end else if (addr_i == `BFSC_ADDR_STANDBY) begin
        st_nxt.rdata = {2'h0, st_r.sp_standby};
      end else if (addr_i == `BFSC_ADDR_SLEEP) begin
        st_nxt.rdata = {2'h0, st_r.sp_sleep};
      end else if (addr_i == `BFSC_ADDR_MODE) begin
        st_nxt.rdata = {2'h0, st_r.sleep_beh, 1'h0, st_r.mode};
      end else if (addr_i == `BFSC_ADDR_CONF) begin
        st_nxt.rdata = st_r.conf;
      end
    end else begin
      st_nxt.rdata = st_r.rdata; // Hold last read byte between reads
    end

    // Target voltage: tracking halves the third output, else the set point
    st_nxt.act_code = sel_code;
    if (track_variant_i) begin
      st_nxt.act_mv = {1'b0, reg3_mv_i[15:1]};
    end else begin
      st_nxt.act_mv = dec_mv;
    end

    // Switching behaviour: tracking ignores PFM and APS selections
    if (track_variant_i) begin
      st_nxt.act_mode = `BFSC_MODE_PWM;
    end else if (bfsc_pkg::bfsc_pstate_t'(power_state_i) == bfsc_pkg::BFSC_PS_SLEEP) begin
      st_nxt.act_mode = st_r.sleep_beh ? `BFSC_MODE_PFM : `BFSC_MODE_OFF;
    end else begin
      st_nxt.act_mode = st_r.mode;
    end
    st_nxt.locked = (st_nxt.lock == bfsc_pkg::BFSC_ST_LOCKED);
  end

  // Single state register; synchronous reset to documented defaults
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_r.lock <= bfsc_pkg::BFSC_ST_OPEN;
      st_r.sp_normal <= `BFSC_RST_SETPOINT;
      st_r.sp_standby <= `BFSC_RST_SETPOINT;
      st_r.sp_sleep <= `BFSC_RST_SETPOINT;
      st_r.mode <= `BFSC_RST_MODE;
      st_r.sleep_beh <= `BFSC_RST_SLEEP_BEH;
      st_r.conf <= `BFSC_RST_CONF;
      st_r.rdata <= 8'h00;
      st_r.act_code <= `BFSC_RST_SETPOINT;
      st_r.act_mv <= 16'h0000;
      st_r.act_mode <= `BFSC_RST_MODE;
      st_r.track <= 1'b0;
      st_r.locked <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign rdata_o = st_r.rdata;
  assign active_code_o = st_r.act_code;
  assign target_mv_o = st_r.act_mv;
  assign active_mode_o = st_r.act_mode;
  assign tracking_o = st_r.track;
  assign locked_o = st_r.locked;
  assign conf_o = st_r.conf;
endmodule // bfsc_top
